// ==== inc/mahi_pkg.sv ====
package mahi_pkg;
	// Clock period in ns
	localparam int CLK_PERIOD_NS = 10;
	// Least sample/hold low time in ns
	localparam int SAMPLE_LOW_NS = 250;
	// Typical fine stage time in ns (separate strobes)
	localparam int FINE_TYP_NS = 600;
	// Typical conversion time in ns (tied strobes)
	localparam int TIED_CONV_NS = 850;
	// Data valid after done flag falls, ns
	localparam int DATA_VALID_NS = 20;
	// Least time, rounded up to cycles
	localparam int SAMPLE_LOW_CYC = (SAMPLE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DATA_VALID_CYC = (DATA_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Watchdog for a missing done flag: twice the tied conversion time
	localparam int DONE_TIMEOUT_CYC = 2 * TIED_CONV_NS / CLK_PERIOD_NS;
	// Result width: six coarse plus four fine bits
	localparam int RESULT_W = 10;
	// Counter width
	localparam int CNT_W = 8;
	// Controller states, one-hot
	typedef enum logic [5:0] {
		MAHI_IDLE = 6'h01,
		MAHI_SAMPLE = 6'h02,
		MAHI_WAIT = 6'h04,
		MAHI_READ = 6'h08,
		MAHI_DONE = 6'h10,
		MAHI_ERR = 6'h20
	} mahi_state_t;
endpackage

// ==== inc/mahi_cnt_if.sv ====
`timescale 1ns/10ps
// Load and expiry of the shared cycle counter
interface mahi_cnt_if;
	logic load; // Load pulse
	logic [7:0] value; // Cycles to count
	logic expired; // Count has run out
	modport ctl (output load, output value, input expired);
	modport tmr (input load, input value, output expired);
endinterface

// ==== verilog/mahi_timer.sv ====
`timescale 1ns/10ps
// Down counter: expired is high once the loaded number of cycles has elapsed
module mahi_timer (
	input wire logic clk,
	input wire logic rst,
	mahi_cnt_if.tmr cnt
);
	logic [7:0] count_r; // Remaining cycles

	// Load or count down to zero
	always_ff @(posedge clk) begin
		if (rst) begin
			count_r <= 8'h00;
		end else if (cnt.load) begin
			count_r <= cnt.value;
		end else if (count_r != 8'h00) begin
			count_r <= count_r - 8'h01;
		end
	end

	// Expiry seen when nothing is left and no load is pending
	assign cnt.expired = (count_r == 8'h00) && !cnt.load;
endmodule

// ==== verilog/mahi_host.sv ====
`timescale 1ns/10ps
module mahi_host #(
	parameter int CHAN_BITS = 2,
	parameter int SAMPLE_CYC = mahi_pkg::SAMPLE_LOW_CYC,
	parameter int VALID_CYC = mahi_pkg::DATA_VALID_CYC,
	parameter int TIMEOUT_CYC = mahi_pkg::DONE_TIMEOUT_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start, // Request a conversion, pulse
	input wire logic tied_mode, // High: strobes tied, read-triggered
	input wire logic [CHAN_BITS-1:0] channel, // Requested input
	output logic busy, // Conversion in progress
	output logic result_valid, // One-cycle pulse with new result
	output logic [mahi_pkg::RESULT_W-1:0] result, // Captured result
	output logic timeout, // One-cycle pulse, no done flag seen
	output logic cs_n, // Chip select
	output logic sample_hold_n, // Sample/hold strobe
	output logic rd_n, // Read strobe
	output logic [CHAN_BITS-1:0] channel_select, // Mux select pins
	input wire logic int_n, // Conversion done flag
	input wire logic [mahi_pkg::RESULT_W-1:0] data_in // Data pins
);
	mahi_pkg::mahi_state_t state_r, state_nxt; // Sequencer state
	logic mode_r; // Latched mode for this conversion
	logic [CHAN_BITS-1:0] chan_r; // Latched channel
	logic [mahi_pkg::RESULT_W-1:0] result_r; // Result register
	logic valid_r; // Result pulse register
	logic timeout_r; // Timeout pulse register
	logic [15:0] wait_r; // Cycles waiting for the flag
	logic setup_r; // First sample cycle: select pins settle, strobes held off
	logic [7:0] sh_low_r; // Cycles the sample strobe has been low, for the width check
	mahi_cnt_if cnt_if ();

	// Shared counter for sample width and data valid delay
	mahi_timer u_timer (.clk(clk), .rst(rst), .cnt(cnt_if));

	// Named decode wires
	wire in_idle = (state_r == mahi_pkg::MAHI_IDLE);
	wire take_start = in_idle && start;
	wire flag_low = !int_n;
	wire waited_out = (wait_r >= 16'(TIMEOUT_CYC));

	// Counter loads on entry to sample and read phases
	assign cnt_if.load = take_start || (state_r == mahi_pkg::MAHI_WAIT && flag_low);
	assign cnt_if.value = take_start ? 8'(SAMPLE_CYC) : 8'(VALID_CYC);

	// Next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			mahi_pkg::MAHI_IDLE: begin
				if (start) begin
					state_nxt = mahi_pkg::MAHI_SAMPLE;
				end
			end
			mahi_pkg::MAHI_SAMPLE: begin
				// Tied mode skips the release and waits for the flag
				if (mode_r || cnt_if.expired) begin
					state_nxt = mahi_pkg::MAHI_WAIT;
				end
			end
			mahi_pkg::MAHI_WAIT: begin
				if (flag_low) begin
					state_nxt = mahi_pkg::MAHI_READ;
				end else if (waited_out) begin
					state_nxt = mahi_pkg::MAHI_ERR;
				end
			end
			mahi_pkg::MAHI_READ: begin
				if (cnt_if.expired) begin
					state_nxt = mahi_pkg::MAHI_DONE;
				end
			end
			mahi_pkg::MAHI_DONE: begin
				state_nxt = mahi_pkg::MAHI_IDLE;
			end
			mahi_pkg::MAHI_ERR: begin
				state_nxt = mahi_pkg::MAHI_IDLE;
			end
			default: begin
				state_nxt = mahi_pkg::MAHI_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= mahi_pkg::MAHI_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Mode and channel latched at accept, held through sample fall
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_r <= 1'b0;
			chan_r <= '0;
		end else if (take_start) begin
			mode_r <= tied_mode;
			chan_r <= channel;
		end
	end

	// Select pins lead the sample strobe fall by one cycle, so the mux sees settled levels
	always_ff @(posedge clk) begin
		if (rst) begin
			setup_r <= 1'b0;
		end else begin
			setup_r <= take_start;
		end
	end

	// Flag wait counter
	always_ff @(posedge clk) begin
		if (rst || state_r != mahi_pkg::MAHI_WAIT) begin
			wait_r <= 16'h0000;
		end else begin
			wait_r <= wait_r + 16'h0001;
		end
	end

	// Result capture after the valid delay; stale data never taken
	always_ff @(posedge clk) begin
		if (rst) begin
			result_r <= '0;
			valid_r <= 1'b0;
			timeout_r <= 1'b0;
		end else begin
			valid_r <= (state_r == mahi_pkg::MAHI_READ) && cnt_if.expired;
			timeout_r <= (state_r == mahi_pkg::MAHI_WAIT) && !flag_low && waited_out;
			if (state_r == mahi_pkg::MAHI_READ && cnt_if.expired) begin
				result_r <= data_in;
			end
		end
	end

	// Strobe decode; select pins stay driven with latched channel
	wire in_sample = (state_r == mahi_pkg::MAHI_SAMPLE) && !setup_r;
	wire in_wait = (state_r == mahi_pkg::MAHI_WAIT);
	wire in_read = (state_r == mahi_pkg::MAHI_READ);
	wire tied_low = mode_r && (in_sample || in_wait || in_read);
	assign sample_hold_n = !(in_sample || tied_low);
	assign rd_n = !(in_read || tied_low);
	assign cs_n = sample_hold_n && rd_n;
	assign channel_select = chan_r;
	assign busy = !in_idle;
	assign result = result_r;
	assign result_valid = valid_r;
	assign timeout = timeout_r;

	// Counts low cycles of the sample strobe, saturating; read only by the width check
	always_ff @(posedge clk) begin
		if (rst || sample_hold_n) begin
			sh_low_r <= 8'h00;
		end else if (sh_low_r != 8'hFF) begin
			sh_low_r <= sh_low_r + 8'h01;
		end
	end

	// Separate mode: at its release the strobe has been low the least sample time
	sequence s_sample_rise;
		$rose(sample_hold_n) && !mode_r;
	endsequence
	property p_sample_width;
		@(posedge clk) disable iff (rst)
		s_sample_rise |-> (sh_low_r >= 8'(SAMPLE_CYC));
	endproperty
	a_sample_low_width: assert property (p_sample_width)
		else $error("sample strobe too short");

	a_cs_with_strobe: assert property (@(posedge clk) disable iff (rst)
		(!sample_hold_n || !rd_n) |-> !cs_n) else $error("strobe without chip select");

	a_read_after_flag: assert property (@(posedge clk) disable iff (rst)
		($fell(rd_n) && !mode_r) |-> $past(!int_n)) else $error("read before done flag");

	a_chan_stable_busy: assert property (@(posedge clk) disable iff (rst)
		(busy && $past(busy)) |-> $stable(channel_select)) else $error("channel moved");

	a_chan_setup_fall: assert property (@(posedge clk) disable iff (rst)
		$fell(sample_hold_n) |-> $stable(channel_select)) else $error("select moved at sample");

	a_tied_strobes_equal: assert property (@(posedge clk) disable iff (rst)
		mode_r |-> (sample_hold_n == rd_n)) else $error("tied strobes differ");

	a_no_start_busy: assert property (@(posedge clk) disable iff (rst)
		(busy && start && !in_idle) |=> !$fell(sample_hold_n) || $past(state_r == mahi_pkg::MAHI_DONE)
		|| $past(state_r == mahi_pkg::MAHI_ERR)) else $error("start taken while busy");

	a_valid_delay: assert property (@(posedge clk) disable iff (rst)
		(in_wait && flag_low) |-> ##[2:4] result_valid) else $error("capture delay wrong");

	// Capture happens on the same edge that raises the valid pulse, taking data_in from the cycle before
	a_result_captured: assert property (@(posedge clk) disable iff (rst)
		result_valid |-> result == $past(data_in)) else $error("result not captured");

	// Read strobe rises in the done or error state, idle follows
	a_release_after_read: assert property (@(posedge clk) disable iff (rst)
		$rose(rd_n) |-> cs_n ##1 in_idle) else $error("bus not released");
endmodule

// ==== test/mahi_dev_model.sv ====
`timescale 1ns/10ps
// Behavioural converter, timed by the bench clock
module mahi_dev_model #(
	parameter int CHAN_BITS = 2, // 2: four-input variant, 1: two-input variant
	parameter int FINE_CYC = 6,
	parameter int TIED_CYC = 9,
	parameter int DV_CYC = 2
) (
	input wire logic clk,
	input wire logic mute, // High: conversions never finish
	input wire logic cs_n,
	input wire logic sample_hold_n,
	input wire logic rd_n,
	input wire logic [CHAN_BITS-1:0] channel_select,
	output logic int_n,
	output logic [9:0] data_out
);
	logic sh_q = 1'b1; // Last strobe levels
	logic rd_q = 1'b1;
	logic conv = 1'b0; // Conversion in progress
	int tmr = 0; // Stage timer
	int dv = 0; // Delay before new data shows
	logic [7:0] samples = 8'h00; // Samples taken so far
	logic [1:0] chan = 2'h0;
	logic [9:0] res = 10'h000;
	logic [9:0] shown = 10'h000; // Word on the pins while read
	wire sh_act = !cs_n && !sample_hold_n; // Gated strobe
	initial int_n = 1'b1;
	initial data_out = 10'h000;
	// Sequencing of sample, coarse, fine and done
	always @(posedge clk) begin
		sh_q <= sample_hold_n;
		rd_q <= rd_n;
		if (sh_act && sh_q && !conv) begin // One sample per strobe fall
			chan <= 2'(channel_select);
			samples <= samples + 8'h01;
			conv <= 1'b1;
			tmr <= !rd_n ? TIED_CYC : 0; // Tied strobes: timer runs the whole conversion; separate: coarse ends at strobe rise
		end else if (conv && sample_hold_n && !sh_q && tmr == 0) begin
			tmr <= FINE_CYC;
		end else if (conv && tmr > 1 && !mute) begin
			tmr <= tmr - 1;
		end else if (conv && tmr == 1 && !mute) begin // Latch word
			int_n <= 1'b0;
			res <= {chan, samples};
			conv <= 1'b0;
			tmr <= 0;
			dv <= DV_CYC;
		end
		// Old word stays until shortly after the flag
		if (dv == 1)
			shown <= res;
		if (dv > 0)
			dv <= dv - 1;
		if (rd_n && !rd_q)
			int_n <= 1'b1;
		// Released bus toggles instead of holding
		data_out <= (!cs_n && !rd_n) ? shown : ~data_out;
	end
endmodule

// ==== test/multistep_adc_host_interface_tb.sv ====
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %0t got %h want %h", $time, g, e); end end
module multistep_adc_host_interface_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic tied_mode = 1'b0;
	logic mute = 1'b0; // Stalls the converter
	logic [1:0] channel = 2'h0;
	logic busy, result_valid, timeout, cs_n, sample_hold_n, rd_n, int_n;
	logic [9:0] result, data_in;
	logic [1:0] channel_select;
	// Two-input variant, run in lockstep with the four-input one
	logic busy_2ch, valid_2ch, timeout_2ch, cs_n_2ch, sh_n_2ch, rd_n_2ch, int_n_2ch;
	logic [9:0] result_2ch, data_2ch;
	logic chan_sel_2ch;
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [7:0] n_conv = 8'h00; // Conversions the converter has run
	// Clock
	always #5 clk = ~clk;
	mahi_host uut (.clk(clk), .rst(rst), .start(start), .tied_mode(tied_mode),
		.channel(channel), .busy(busy), .result_valid(result_valid), .result(result),
		.timeout(timeout), .cs_n(cs_n), .sample_hold_n(sample_hold_n), .rd_n(rd_n),
		.channel_select(channel_select), .int_n(int_n), .data_in(data_in));
	mahi_dev_model dev (.clk(clk), .mute(mute), .cs_n(cs_n), .sample_hold_n(sample_hold_n),
		.rd_n(rd_n), .channel_select(channel_select), .int_n(int_n), .data_out(data_in));
	mahi_host #(.CHAN_BITS(1)) uut_2ch (.clk(clk), .rst(rst), .start(start),
		.tied_mode(tied_mode), .channel(channel[0]), .busy(busy_2ch), .result_valid(valid_2ch),
		.result(result_2ch), .timeout(timeout_2ch), .cs_n(cs_n_2ch), .sample_hold_n(sh_n_2ch),
		.rd_n(rd_n_2ch), .channel_select(chan_sel_2ch), .int_n(int_n_2ch), .data_in(data_2ch));
	mahi_dev_model #(.CHAN_BITS(1)) dev_2ch (.clk(clk), .mute(mute), .cs_n(cs_n_2ch),
		.sample_hold_n(sh_n_2ch), .rd_n(rd_n_2ch), .channel_select(chan_sel_2ch),
		.int_n(int_n_2ch), .data_out(data_2ch));
	// Verdict and end of run
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			miscompares++;
			summarize();
		end
	end
	// One conversion; poke retries start while busy
	task automatic conv(input logic tm, input logic [1:0] ch, input logic poke);
		int w;
		@(posedge clk) #1;
		start = 1'b1;
		tied_mode = tm;
		channel = ch;
		@(posedge clk) #1;
		start = 1'b0;
		n_conv = n_conv + 8'h01;
		`CHK(busy, 1'b1)
		@(posedge clk) #1;
		`CHK({cs_n, sample_hold_n, rd_n}, {2'b00, !tm})
		if (poke) begin
			repeat (8) @(posedge clk);
			#1 start = 1'b1;
			channel = ~ch;
			@(posedge clk) #1;
			start = 1'b0;
		end
		w = 0;
		while (result_valid !== 1'b1 && w < 400) begin
			@(posedge clk) #1;
			w++;
		end
		`CHK(result_valid, 1'b1)
		`CHK(result, {ch, n_conv})
		`CHK(channel_select, ch)
		`CHK(valid_2ch, 1'b1)
		`CHK(result_2ch, {1'b0, ch[0], n_conv})
		`CHK(chan_sel_2ch, ch[0])
		@(posedge clk) #1;
		`CHK({busy, cs_n, sample_hold_n, rd_n}, 4'h7)
		$display("test conv mode %0d ch %0d done", tm, ch);
	endtask
	// Converter never answers
	task automatic stall;
		int w;
		mute = 1'b1;
		@(posedge clk) #1;
		start = 1'b1;
		@(posedge clk) #1;
		start = 1'b0;
		w = 0;
		while (timeout !== 1'b1 && w < 300) begin
			@(posedge clk) #1;
			w++;
		end
		`CHK(timeout, 1'b1)
		`CHK(timeout_2ch, 1'b1)
		@(posedge clk) #1;
		`CHK(busy, 1'b0)
		$display("test stall done");
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		#1 rst = 1'b0;
		for (int i = 0; i < 4; i++)
			conv(1'b0, 2'(i), i == 1);
		for (int i = 0; i < 4; i++)
			conv(1'b1, 2'(i), i == 2);
		stall();
		summarize();
	end
endmodule
